/* File: logic/cbsf_top.sv */
`timescale 1ns/1ps
module cbsf_top
    import cbsf_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    // core clock and reset
    input  wire logic                CLK_IN,
    input  wire logic                RESET_IN,
    // configuration serial bus
    input  wire logic                CONFIG_SERIAL_CLOCK_IN,
    input  wire logic                CONFIG_SELECT_N_IN,
    input  wire logic                CONFIG_SERIAL_IN,
    output logic                     CONFIG_SERIAL_OUT,
    output logic                     SAMPLE_SERIAL_OUT_FIRST_OUT,
    // checksum enable fields from the bus configuration register
    input  wire logic [1:0]          CHK_ENABLE_IN,
    input  wire logic [1:0]          CHK_ENABLE_N_IN,
    // health sources from internal monitors
    input  wire logic                FUSE_FAULT_IN,
    input  wire logic [7:0]          MAP_CHECK_CALC_IN,
    input  wire logic [7:0]          MAP_CHECK_STORED_IN,
    input  wire logic [CHANNELS-1:0] CH_OVERRANGE_IN,
    input  wire logic [CHANNELS-1:0] CH_UNDERRANGE_IN,
    input  wire logic [CHANNELS-1:0] CH_SLEEP_IN,
    input  wire logic                POWER_DOWN_IN,
    // power-on initialisation
    output logic                     BUSY_OUT
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    localparam logic [15:0] INIT_LAST = 16'(INIT_CYCLES - 1);

    cbsf_state_type state_q;
    cbsf_state_type state_d;

    logic        cs_n_s1_q;
    logic        cs_n_s2_q;
    logic        link_clear_q;
    logic        ignore_q;
    logic        busy_q;
    logic [15:0] init_cnt_q;
    logic        not_rdy_q;
    logic        edge_err_q;
    logic        chk_err_q;
    logic        wr_inv_q;
    logic        addr_inv_q;
    logic        route_q;
    logic        ready_q;
    logic        reset_evt_q;
    logic        fuse_q;
    logic        map_q;
    logic [23:0] img_q;

    logic [23:0] link_shift_q;
    logic [5:0]  link_cnt_q;
    logic [7:0]  link_cmd_q;
    logic        cfg_out_q;
    logic        smp_out_q;

    // set wins over a clearing write
    function automatic logic flag_next(input logic q, input logic set, input logic clr);
        return set | (q & ~clr);
    endfunction : flag_next

    ////////////////////////////////////////////////////////////////////////////
    // frame sequencing in the core domain

    // link registers are only read in ST_FINISH, when the serial clock is
    // idle and link_clear_q still low, so the words are stable
    wire frame_start = (state_q == ST_IDLE) & ~cs_n_s2_q;
    wire frame_end   = (state_q == ST_FRAME) & cs_n_s2_q;
    wire finishing   = (state_q == ST_FINISH);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:   if (frame_start) state_d = ST_FRAME;
            ST_FRAME:  if (frame_end) state_d = ST_FINISH;
            ST_FINISH: state_d = ST_IDLE;
            default:   state_d = ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame decode

    wire       chk_on     = (CHK_ENABLE_IN == CHK_EN_ON) & (CHK_ENABLE_N_IN == CHK_EN_N_ON);
    wire [5:0] edges_exp  = chk_on ? EDGES_CHECKED : EDGES_PLAIN;
    wire [7:0] cmd_byte   = chk_on ? link_shift_q[23:16] : link_shift_q[15:8];
    wire [7:0] wdat       = chk_on ? link_shift_q[15:8] : link_shift_q[7:0];
    wire [7:0] chk_recv   = link_shift_q[7:0];
    wire [7:0] chk_calc   = cbsf_crc8({cmd_byte, wdat});
    wire [6:0] addr       = cmd_byte[6:0];
    wire       is_write   = ~cmd_byte[7];

    wire fin       = finishing & ~ignore_q;
    wire edge_bad  = fin & (link_cnt_q != edges_exp);
    wire chk_bad   = fin & ~edge_bad & chk_on & (chk_recv != chk_calc);
    wire good      = fin & ~edge_bad & ~chk_bad;

    wire hit_err   = (addr == ADDR_ERR_FLAGS);
    wire hit_route = (addr == ADDR_ROUTING);
    wire hit_hlth  = (addr == ADDR_HEALTH);
    wire hit_ro    = (addr >= ADDR_RO_FIRST) & (addr <= ADDR_RO_LAST);

    wire addr_bad  = good & ~(hit_err | hit_route | hit_hlth | hit_ro);
    wire wr_ro     = good & is_write & hit_ro;
    wire wr_err    = good & is_write & hit_err;
    wire wr_route  = good & is_write & hit_route;
    wire wr_hlth   = good & is_write & hit_hlth;

    wire not_rdy_set = frame_start & busy_q;
    wire init_done   = busy_q & (init_cnt_q == INIT_LAST);
    wire map_bad     = (MAP_CHECK_CALC_IN != MAP_CHECK_STORED_IN);

    ////////////////////////////////////////////////////////////////////////////
    // readback values

    // reserved positions are constant zero, writes never reach them
    wire [7:0] err_rd = {not_rdy_q, 2'b00, edge_err_q, chk_err_q,
                         wr_inv_q, 1'b0, addr_inv_q};
    wire [7:0] route_rd  = {7'h00, route_q};
    wire       bus_err   = |err_rd;
    wire       range_err = |{CH_OVERRANGE_IN, CH_UNDERRANGE_IN};
    wire       sleep_any = |CH_SLEEP_IN;
    wire [7:0] hlth_rd   = {ready_q, reset_evt_q, fuse_q, map_q,
                            bus_err, range_err, POWER_DOWN_IN, sleep_any};

    ////////////////////////////////////////////////////////////////////////////
    // core registers

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            state_q      <= ST_IDLE;
            cs_n_s1_q    <= 1'b1;
            cs_n_s2_q    <= 1'b1;
            link_clear_q <= 1'b1;
            ignore_q     <= 1'b0;
        end else begin
            state_q      <= state_d;
            cs_n_s1_q    <= CONFIG_SELECT_N_IN;
            cs_n_s2_q    <= cs_n_s1_q;
            link_clear_q <= (state_d == ST_IDLE);
            if (frame_start) begin
                ignore_q <= busy_q;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            busy_q     <= 1'b1;
            init_cnt_q <= 16'h0000;
        end else begin
            busy_q     <= busy_q & ~init_done;
            init_cnt_q <= busy_q ? init_cnt_q + 16'h0001 : init_cnt_q;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            not_rdy_q  <= ERR_FLAGS_RST[BIT_NOT_READY];
            edge_err_q <= ERR_FLAGS_RST[BIT_EDGE_COUNT];
            chk_err_q  <= ERR_FLAGS_RST[BIT_CHECKSUM];
            wr_inv_q   <= ERR_FLAGS_RST[BIT_WRITE_INV];
            addr_inv_q <= ERR_FLAGS_RST[BIT_ADDR_INV];
        end else begin
            not_rdy_q  <= flag_next(not_rdy_q, not_rdy_set,
                                    wr_err & wdat[BIT_NOT_READY]);
            edge_err_q <= edge_bad | (wr_err ? wdat[BIT_EDGE_COUNT] : edge_err_q);
            chk_err_q  <= flag_next(chk_err_q, chk_bad,
                                    wr_err & wdat[BIT_CHECKSUM]);
            wr_inv_q   <= flag_next(wr_inv_q, wr_ro,
                                    wr_err & wdat[BIT_WRITE_INV]);
            addr_inv_q <= flag_next(addr_inv_q, addr_bad,
                                    wr_err & wdat[BIT_ADDR_INV]);
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            route_q <= ROUTING_RST[BIT_ROUTE_SEL];
        end else if (wr_route) begin
            route_q <= wdat[BIT_ROUTE_SEL];
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            ready_q     <= HEALTH_RST[BIT_READY];
            reset_evt_q <= HEALTH_RST[BIT_RESET_EVT];
            fuse_q      <= HEALTH_RST[BIT_FUSE];
            map_q       <= HEALTH_RST[BIT_MAP_CHK];
        end else begin
            // a fuse fault after start-up drops ready so the host sees it must reset
            ready_q     <= ~FUSE_FAULT_IN & (ready_q | init_done);
            reset_evt_q <= flag_next(reset_evt_q, 1'b0,
                                     wr_hlth & wdat[BIT_RESET_EVT]);
            fuse_q      <= flag_next(fuse_q, FUSE_FAULT_IN,
                                     wr_hlth & wdat[BIT_FUSE]);
            map_q       <= flag_next(map_q, map_bad,
                                     wr_hlth & wdat[BIT_MAP_CHK]);
        end
    end

    // readback image frozen for the whole frame so the link sees stable words
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            img_q <= {HEALTH_RST, ROUTING_RST, ERR_FLAGS_RST};
        end else if (state_q == ST_IDLE) begin
            img_q <= {hlth_rd, route_rd, err_rd};
        end
    end

    assign BUSY_OUT = busy_q;

    ////////////////////////////////////////////////////////////////////////////
    // link domain: shift in on rising edge, shift out on falling edge

    // link_clear_q acts as a reset from the core; the host keeps the serial
    // clock idle around its edges (select setup time), so no edge races it
    always_ff @(posedge CONFIG_SERIAL_CLOCK_IN or posedge link_clear_q) begin
        if (link_clear_q) begin
            link_shift_q <= 24'h000000;
            link_cnt_q   <= 6'h00;
            link_cmd_q   <= 8'h00;
        end else begin
            link_shift_q <= {link_shift_q[22:0], CONFIG_SERIAL_IN};
            link_cnt_q   <= (link_cnt_q == EDGES_MAX) ? link_cnt_q : link_cnt_q + 6'h01;
            if (link_cnt_q == EDGES_CMD - 6'h01) begin
                link_cmd_q <= {link_shift_q[6:0], CONFIG_SERIAL_IN};
            end
        end
    end

    wire [6:0] link_addr = link_cmd_q[6:0];
    wire [7:0] rd_byte   = (link_addr == ADDR_ERR_FLAGS) ? img_q[7:0]   :
                           (link_addr == ADDR_ROUTING)   ? img_q[15:8]  :
                           (link_addr == ADDR_HEALTH)    ? img_q[23:16] : 8'h00;
    wire       rd_active = link_cmd_q[7] & (link_cnt_q >= EDGES_CMD) &
                           (link_cnt_q < EDGES_PLAIN);
    wire [2:0] rd_idx    = ~link_cnt_q[2:0];
    wire       rd_bit    = rd_active & rd_byte[rd_idx];
    wire       img_route = img_q[8 + BIT_ROUTE_SEL];

    always_ff @(negedge CONFIG_SERIAL_CLOCK_IN or posedge link_clear_q) begin
        if (link_clear_q) begin
            cfg_out_q <= 1'b0;
            smp_out_q <= 1'b0;
        end else begin
            cfg_out_q <= rd_bit & ~img_route;
            smp_out_q <= rd_bit & img_route;
        end
    end

    assign CONFIG_SERIAL_OUT           = cfg_out_q;
    assign SAMPLE_SERIAL_OUT_FIRST_OUT = smp_out_q;

endmodule : cbsf_top

/* File: shared/cbsf_pkg.sv */
package cbsf_pkg;

    // register addresses on the configuration bus
    localparam logic [6:0] ADDR_ERR_FLAGS = 7'h11;
    localparam logic [6:0] ADDR_ROUTING   = 7'h14;
    localparam logic [6:0] ADDR_HEALTH    = 7'h20;
    // read-only identification registers served by a neighbouring block
    localparam logic [6:0] ADDR_RO_FIRST  = 7'h0b;
    localparam logic [6:0] ADDR_RO_LAST   = 7'h0d;

    // bus error flags fields
    localparam int BIT_NOT_READY  = 7;
    localparam int BIT_EDGE_COUNT = 4;
    localparam int BIT_CHECKSUM   = 3;
    localparam int BIT_WRITE_INV  = 2;
    localparam int BIT_ADDR_INV   = 0;

    // routing field
    localparam int BIT_ROUTE_SEL = 0;

    // health summary fields
    localparam int BIT_READY     = 7;
    localparam int BIT_RESET_EVT = 6;
    localparam int BIT_FUSE      = 5;
    localparam int BIT_MAP_CHK   = 4;
    localparam int BIT_BUS_ERR   = 3;
    localparam int BIT_RANGE_ERR = 2;
    localparam int BIT_POWERDOWN = 1;
    localparam int BIT_SLEEP     = 0;

    // values after reset
    localparam logic [7:0] ERR_FLAGS_RST = 8'h00;
    localparam logic [7:0] ROUTING_RST   = 8'h00;
    localparam logic [7:0] HEALTH_RST    = 8'h40;

    // checksum enable field codes
    localparam logic [1:0] CHK_EN_ON   = 2'h1;
    localparam logic [1:0] CHK_EN_N_ON = 2'h2;

    // serial clock edges per frame
    localparam logic [5:0] EDGES_PLAIN   = 6'h10;
    localparam logic [5:0] EDGES_CHECKED = 6'h18;
    localparam logic [5:0] EDGES_CMD     = 6'h08;
    localparam logic [5:0] EDGES_MAX     = 6'h3f;

    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int INIT_TIME_NS  = 10000;
    localparam int INIT_CYCLES   = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [7:0] CHK_POLY = 8'h07;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_FRAME  = 2'b01,
        ST_FINISH = 2'b10
    } cbsf_state_type;

    // msb-first crc-8 over command and data byte, zero seed
    function automatic logic [7:0] cbsf_crc8(input logic [15:0] data);
        logic [7:0] c;
        logic       fb;
        c  = 8'h00;
        fb = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            fb = c[7] ^ data[i];
            c  = {c[6:0], 1'b0} ^ (fb ? CHK_POLY : 8'h00);
        end
        return c;
    endfunction : cbsf_crc8

endpackage : cbsf_pkg

/* File: sim/cbsf_props.sv */
`timescale 1ns/1ps
module cbsf_props
    import cbsf_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic CONFIG_SELECT_N_IN,
    input wire logic CONFIG_SERIAL_OUT,
    input wire logic SAMPLE_SERIAL_OUT_FIRST_OUT,
    input wire logic BUSY_OUT
);
    logic [8:0] rel_cnt_q;
    wire        outs_low = !CONFIG_SERIAL_OUT && !SAMPLE_SERIAL_OUT_FIRST_OUT;
    // saturates so a long run cannot wrap into a false busy window
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            rel_cnt_q <= 9'h000;
        end else if (rel_cnt_q != 9'h1ff) begin
            rel_cnt_q <= rel_cnt_q + 9'h001;
        end
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    ////////////////////////////////////////////////////////////////////////////
    a_busy_in_reset: assert property (disable iff (1'b0) RESET_IN |=> BUSY_OUT)
        else $error("busy low after reset");
    a_outs_reset: assert property (disable iff (1'b0) RESET_IN |=> outs_low)
        else $error("serial output active in reset");
    a_busy_length: assert property ($fell(BUSY_OUT) |-> rel_cnt_q inside {[198:202]})
        else $error("busy fell at wrong count");
    a_busy_ends: assert property (rel_cnt_q == 9'h0d2 |-> !BUSY_OUT)
        else $error("busy never fell");
    a_busy_stays_low: assert property (!BUSY_OUT |=> !BUSY_OUT)
        else $error("busy rose without reset");
    a_quiet_while_busy: assert property (BUSY_OUT |-> outs_low)
        else $error("frame answered while busy");
    a_one_route_only: assert property (!(CONFIG_SERIAL_OUT && SAMPLE_SERIAL_OUT_FIRST_OUT))
        else $error("both readback pins driven");
    a_idle_quiet: assert property (CONFIG_SELECT_N_IN [*8] |-> outs_low)
        else $error("readback active between frames");
    a_rise_in_frame: assert property (($rose(CONFIG_SERIAL_OUT) ||
        $rose(SAMPLE_SERIAL_OUT_FIRST_OUT)) |-> !CONFIG_SELECT_N_IN)
        else $error("readback rose outside frame");
    c_init_done: cover property ($fell(BUSY_OUT));
    c_read_main: cover property ($rose(CONFIG_SERIAL_OUT));
    c_read_alt: cover property ($rose(SAMPLE_SERIAL_OUT_FIRST_OUT));
endmodule : cbsf_props

bind cbsf_top cbsf_props #(.CHANNELS(CHANNELS)) u_props (
    .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .CONFIG_SELECT_N_IN(CONFIG_SELECT_N_IN),
    .CONFIG_SERIAL_OUT(CONFIG_SERIAL_OUT),
    .SAMPLE_SERIAL_OUT_FIRST_OUT(SAMPLE_SERIAL_OUT_FIRST_OUT), .BUSY_OUT(BUSY_OUT));

/* File: sim/cbsf_host.sv */
`timescale 1ns/1ps
module cbsf_host (
    // serial bus towards the device
    output logic      sclk_out,
    output logic      sel_n_out,
    output logic      sdi_out,
    input  wire logic sdo_main_in,
    input  wire logic sdo_alt_in
);
    initial begin
        sclk_out  = 1'b0;
        sel_n_out = 1'b1;
        sdi_out   = 1'b0;
    end
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction : crc8
    // n above 16 appends the checksum byte; bad flips it to provoke a refusal
    task automatic frame(input logic [7:0] cmd, input logic [7:0] dat, input int n,
                         input logic bad, output logic [7:0] rm, output logic [7:0] ra);
        logic [23:0] sh;
        sh = {cmd, dat, crc8({cmd, dat}) ^ {8{bad}}};
        rm = 8'h00;
        ra = 8'h00;
        sel_n_out = 1'b0;
        #200;
        for (int i = 0; i < n; i++) begin
            sdi_out = sh[23 - (i % 24)];
            #7.5 sclk_out = 1'b1;
            if (i >= 8 && i < 16) begin
                rm[15 - i] = sdo_main_in;
                ra[15 - i] = sdo_alt_in;
            end
            #7.5 sclk_out = 1'b0;
        end
        // released data line must not keep the last bit
        sdi_out = ~sdi_out;
        #7.5 sel_n_out = 1'b1;
        #400;
    endtask : frame
endmodule : cbsf_host

/* File: sim/tb_config_bus_status_flags.sv */
`timescale 1ns/1ps
module tb_config_bus_status_flags;
    import cbsf_pkg::*;
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e); end end
    logic       clk, rst, sclk, sel_n, sdi, sdo_m, sdo_a, fuse, pd, busy, route;
    logic [1:0] en, en_n;
    logic [7:0] calc, stored, ovr, und, slp, r;
    int         failures, compares, cycles, edges;
    cbsf_host host (.sclk_out(sclk), .sel_n_out(sel_n), .sdi_out(sdi),
                    .sdo_main_in(sdo_m), .sdo_alt_in(sdo_a));
    cbsf_top #(.CHANNELS(8)) uut (.CLK_IN(clk), .RESET_IN(rst),
        .CONFIG_SERIAL_CLOCK_IN(sclk), .CONFIG_SELECT_N_IN(sel_n), .CONFIG_SERIAL_IN(sdi),
        .CONFIG_SERIAL_OUT(sdo_m), .SAMPLE_SERIAL_OUT_FIRST_OUT(sdo_a),
        .CHK_ENABLE_IN(en), .CHK_ENABLE_N_IN(en_n), .FUSE_FAULT_IN(fuse),
        .MAP_CHECK_CALC_IN(calc), .MAP_CHECK_STORED_IN(stored), .CH_OVERRANGE_IN(ovr),
        .CH_UNDERRANGE_IN(und), .CH_SLEEP_IN(slp), .POWER_DOWN_IN(pd), .BUSY_OUT(busy));
    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic xfer(input logic [7:0] c, input logic [7:0] d, input logic bad,
                        output logic [7:0] q);
        logic [7:0] m, a;
        host.frame(c, d, edges, bad, m, a);
        q = route ? a : m;
        `CHK(route ? m : a, 8'h00, "unrouted pin")
    endtask : xfer
    task automatic wr(input logic [6:0] ad, input logic [7:0] d);
        logic [7:0] q;
        xfer({1'b0, ad}, d, 1'b0, q);
    endtask : wr
    task automatic rd(input logic [6:0] ad, input logic [7:0] e);
        logic [7:0] q;
        xfer({1'b1, ad}, 8'h00, 1'b0, q);
        `CHK(q, e, "register read")
    endtask : rd
    // early sends one frame while initialisation is still running
    task automatic do_reset(input logic early);
        int k;
        @(negedge clk) rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        if (early) begin
            rd(ADDR_ERR_FLAGS, 8'h00);
        end
        k = 0;
        while (busy !== 1'b0 && k < 400) begin
            @(negedge clk);
            k++;
        end
        `CHK(busy, 1'b0, "busy end")
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            $display("MISMATCH t=%0t run timed out", $time);
            close_out();
        end
    end
    initial begin
        {rst, fuse, pd, route} = 4'h8;
        {en, en_n, calc, stored, ovr, und, slp} = 44'h0;
        {failures, compares, cycles, edges} = {32'h0, 32'h0, 32'h0, 32'h10};
        do_reset(1'b0);
        rd(ADDR_HEALTH, 8'hc0);
        rd(ADDR_ERR_FLAGS, 8'h00);
        rd(ADDR_ROUTING, 8'h00);
        $display("test reset values done");
        do_reset(1'b1);
        rd(ADDR_ERR_FLAGS, 8'h80);
        rd(ADDR_HEALTH, 8'hc8);
        wr(ADDR_ERR_FLAGS, 8'h00);
        rd(ADDR_ERR_FLAGS, 8'h80);
        wr(ADDR_ERR_FLAGS, 8'h80);
        rd(ADDR_ERR_FLAGS, 8'h00);
        wr(ADDR_HEALTH, 8'hff);
        rd(ADDR_HEALTH, 8'h80);
        $display("test not-ready done");
        xfer({1'b1, 7'h30}, 8'h00, 1'b0, r);
        rd(ADDR_ERR_FLAGS, 8'h01);
        wr(ADDR_ERR_FLAGS, 8'h01);
        wr(ADDR_RO_FIRST + 7'h01, 8'h55);
        rd(ADDR_ERR_FLAGS, 8'h04);
        rd(ADDR_HEALTH, 8'h88);
        wr(ADDR_ERR_FLAGS, 8'h04);
        host.frame({1'b0, ADDR_ROUTING}, 8'h01, 12, 1'b0, r, r);
        rd(ADDR_ERR_FLAGS, 8'h10);
        rd(ADDR_ROUTING, 8'h00);
        wr(ADDR_ERR_FLAGS, 8'hff);
        rd(ADDR_ERR_FLAGS, 8'h10);
        wr(ADDR_ERR_FLAGS, 8'h00);
        rd(ADDR_ERR_FLAGS, 8'h00);
        $display("test access errors done");
        @(negedge clk) {en, en_n} = {CHK_EN_ON, CHK_EN_N_ON};
        edges = 24;
        wr(ADDR_ROUTING, 8'hff);
        route = 1'b1;
        rd(ADDR_ROUTING, 8'h01);
        xfer({1'b0, ADDR_ROUTING}, 8'h00, 1'b1, r);
        rd(ADDR_ERR_FLAGS, 8'h08);
        rd(ADDR_ROUTING, 8'h01);
        wr(ADDR_ERR_FLAGS, 8'h08);
        wr(ADDR_ROUTING, 8'h00);
        route = 1'b0;
        @(negedge clk) en_n = 2'h3;
        edges = 16;
        rd(ADDR_ERR_FLAGS, 8'h00);
        $display("test checksum done");
        for (int k = 0; k < 4; k++) begin
            @(negedge clk) {ovr, und, slp, pd} = {7'h0, k == 0, 7'h0, k == 1, 7'h0, k == 2,
                                                  k == 3};
            rd(ADDR_HEALTH, 8'h80 | (k < 2 ? 8'h04 : (k == 2 ? 8'h01 : 8'h02)));
        end
        @(negedge clk) {ovr, und, slp, pd, calc} = {25'h0, 8'h5a};
        rd(ADDR_HEALTH, 8'h90);
        wr(ADDR_HEALTH, 8'h10);
        rd(ADDR_HEALTH, 8'h90);
        @(negedge clk) stored = 8'h5a;
        wr(ADDR_HEALTH, 8'h10);
        rd(ADDR_HEALTH, 8'h80);
        @(negedge clk) fuse = 1'b1;
        @(negedge clk) fuse = 1'b0;
        rd(ADDR_HEALTH, 8'h20);
        wr(ADDR_HEALTH, 8'h20);
        rd(ADDR_HEALTH, 8'h00);
        do_reset(1'b0);
        rd(ADDR_HEALTH, 8'hc0);
        $display("test health sources done");
        close_out();
    end
endmodule : tb_config_bus_status_flags
